/* fsr_pkg.sv */
package fsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS1  = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_ERASE_4K      = 8'h20;
    localparam logic [7:0] OP_READ_STATUS2  = 8'h35;
    localparam logic [7:0] OP_SEC_PROGRAM   = 8'h42;
    localparam logic [7:0] OP_SEC_ERASE     = 8'h44;
    localparam logic [7:0] OP_ERASE_32K     = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
    localparam logic [7:0] OP_ERASE_64K     = 8'hD8;

    ////////////////////////////////////////////////////////////////////////////
    // Status byte one and two field positions
    localparam int SR1_MODE_LO    = 7;
    localparam int SR1_WEL        = 1;
    localparam int SR1_BUSY       = 0;
    localparam int SR2_INVERT     = 6;
    localparam int SR2_LOCK_HI    = 5;
    localparam int SR2_LOCK_LO    = 3;
    localparam int SR2_QUAD       = 1;
    localparam int SR2_MODE_HI    = 0;
    localparam logic [7:0] SR1_WRITE_MASK = 8'hFC;
    localparam logic [7:0] SR2_WRITE_MASK = 8'h7B;
    localparam logic [7:0] SR1_RESET      = 8'h00;
    localparam logic [7:0] SR2_RESET      = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SYNC_STAGES  = 2;
    localparam int FRAME_SETTLE = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [2:0] byteCnt;
        logic [2:0] bitPhase;
    } fsr_frame_t;

    typedef struct packed {
        logic       protect_invert;
        logic       sector_size_sel;
        logic       top_bottom_sel;
        logic [2:0] block_protect;
    } fsr_prot_t;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    function automatic logic isGated(input logic [7:0] op);
        case (op)
            OP_WRITE_STATUS, OP_PAGE_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SEC_PROGRAM, OP_SEC_ERASE: isGated = 1'b1;
            default: isGated = 1'b0;
        endcase
    endfunction

    function automatic logic protAllow(input logic modeHi, input logic modeLo, input logic wpHigh);
        case ({modeHi, modeLo})
            2'b00:   protAllow = 1'b1;
            2'b01:   protAllow = wpHigh;
            default: protAllow = 1'b0;
        endcase
    endfunction

endpackage

/* fsr_sync.sv */
`timescale 1ns/100ps
module fsr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // Stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // fsr_sync

/* fsr_link.sv */
`timescale 1ns/100ps
module fsr_link (
    input  wire logic               sck,
    input  wire logic               csN,
    input  wire logic               si,
    input  wire logic [15:0]        statusBytes,
    output fsr_pkg::fsr_frame_t     frame,
    output logic                    so,
    output logic                    soOe
);
    logic        inFrame;
    logic [6:0]  shiftIn;
    logic [15:0] statusLink;
    logic [2:0]  curBit;
    logic [2:0]  curByte;
    logic [7:0]  rxByte;
    logic [7:0]  txByte;

    // Status is only changed between frames, so the word is stable while it is sampled
    fsr_sync #(.WIDTH(16)) u_status_sync (
        .clk  (sck),
        .rst  (1'b0),
        .din  (statusBytes),
        .dout (statusLink)
    );

    assign curBit  = inFrame ? frame.bitPhase : 3'h0;
    assign curByte = inFrame ? frame.byteCnt : 3'h0;
    assign rxByte  = {shiftIn, si};
    assign txByte  = (frame.opcode == fsr_pkg::OP_READ_STATUS2) ? statusLink[7:0] : statusLink[15:8];

    ////////////////////////////////////////////////////////////////////////////
    // Frame tracking, cleared by chip select rising
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            inFrame <= 1'b0;
            soOe    <= 1'b0;
        end else begin
            inFrame <= 1'b1;
            if (curBit == 3'h7 && curByte == 3'h0 &&
                (rxByte == fsr_pkg::OP_READ_STATUS1 || rxByte == fsr_pkg::OP_READ_STATUS2)) begin
                soOe <= 1'b1;
            end
        end
    end

    // Counts and captured bytes survive the frame end for the system side to read
    always_ff @(posedge sck) begin
        shiftIn        <= rxByte[6:0];
        frame.bitPhase <= curBit + 3'h1;
        frame.byteCnt  <= curByte;
        if (curBit == 3'h7) begin
            if (curByte != 3'h7) begin
                frame.byteCnt <= curByte + 3'h1;
            end
            case (curByte)
                3'h0:    frame.opcode <= rxByte;
                3'h1:    frame.data1  <= rxByte;
                3'h2:    frame.data2  <= rxByte;
                default: ;
            endcase
        end
    end

    // Shift status out on the falling edge, repeating every eight bits
    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            so <= 1'b0;
        end else begin
            so <= txByte[3'h7 - frame.bitPhase];
        end
    end
endmodule // fsr_link

/* fsr_status_protect.sv */
`timescale 1ns/100ps
// Function
// - Status byte two bits 7 and 2 are read-only zero.
// - Byte two bit 6 holds the protection invert flag, default zero.
// - Byte two bits 5..3 lock security pages; set lock blocks page program/erase.
// - Byte two bit 1 is quad enable; one turns hold/protect pins into data.
// - Byte two bit 0 holds the upper protection mode bit.
// - Status writes change only byte one bits 7..2 and byte two bits 6..3, 1 and 0.
// - Mode 00 accepts status writes whenever the latch is set.
// - Mode 01 rejects writes with protect pin low unless quad enable is set, accepts with it high.
// - Mode 10 rejects all status writes until power cycle.
// - Power cycle turns mode 10 back into mode 00.
// - Mode 11 rejects every later status write for good.
// - Array protection fields go to the array decoder.
// - Latch clear makes program, erase and status write commands ignored.
// - Latch clears after power-up and device reset.
// - Latch clears on write-disable and on any gated command ending.
// - Partial or unknown opcode leaves a set latch unchanged.
// - Aborted gated command clears latch only after a full opcode.
// - Opcode 35h shifts byte two out MSB first, repeating until deselect.
// - Status write after latch set updates bits and clears latch at deselect.
// - Byte one: mode low, sector, top-bottom, block bits, latch, busy.
// - Status write not ending on full byte boundary aborts and clears latch.
module fsr_status_protect (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           nvInit,
    input  wire logic           busyIn,
    input  wire logic           opDone,
    input  wire logic           sck,
    input  wire logic           csN,
    input  wire logic           si,
    input  wire logic           wpN,
    output logic                so,
    output logic                soOe,
    output fsr_pkg::fsr_prot_t  protCfg,
    output logic [2:0]          pageLock,
    output logic                quadEnable,
    output logic                writeEnable,
    output logic                cmdStart,
    output logic [7:0]          cmdOpcode
);
    localparam int SYNC_W = $bits(fsr_pkg::fsr_frame_t) + 2;

    fsr_pkg::fsr_frame_t   frameLink;
    fsr_pkg::fsr_frame_t   frameSys;
    logic [SYNC_W-1:0]     syncOut;
    logic                  csSync;
    logic                  wpSync;
    logic                  csPrev;
    logic [fsr_pkg::FRAME_SETTLE-1:0] settle;
    logic                  frameAct;
    logic [7:0]            sr1;
    logic [7:0]            sr2;
    logic                  write_enable_latch;
    logic [7:0]            statusByte1;
    logic [7:0]            statusByte2;
    logic                  fullOpcode;
    logic                  wpHigh;
    logic                  wrsrOk;
    logic                  secBlocked;
    logic [7:0]            next_sr1;
    logic [7:0]            next_sr2;

    ////////////////////////////////////////////////////////////////////////////
    // Link side and crossings
    fsr_link u_link (
        .sck         (sck),
        .csN         (csN),
        .si          (si),
        .statusBytes ({statusByte1, statusByte2}),
        .frame       (frameLink),
        .so          (so),
        .soOe        (soOe)
    );

    fsr_sync #(.WIDTH(SYNC_W)) u_sys_sync (
        .clk  (clk_sys),
        .rst  (rst),
        .din  ({frameLink, ~csN, wpN}),
        .dout (syncOut)
    );

    assign frameSys = syncOut[SYNC_W-1:2];
    // Select crosses inverted so a cleared synchroniser reads as deselected
    assign csSync   = ~syncOut[1];
    assign wpSync   = syncOut[0];

    // Frame captures stop changing before deselect; wait a little more before use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            csPrev <= 1'b1;
            settle <= '0;
        end else begin
            csPrev <= csSync;
            settle <= {settle[fsr_pkg::FRAME_SETTLE-2:0], csSync & ~csPrev};
        end
    end

    assign frameAct = settle[fsr_pkg::FRAME_SETTLE-1];

    ////////////////////////////////////////////////////////////////////////////
    // Status views
    assign statusByte1 = {sr1[7:2], write_enable_latch, busyIn};
    assign statusByte2 = sr2 & fsr_pkg::SR2_WRITE_MASK;
    assign protCfg     = {sr2[fsr_pkg::SR2_INVERT], sr1[6:2]};
    assign pageLock    = sr2[fsr_pkg::SR2_LOCK_HI:fsr_pkg::SR2_LOCK_LO];
    assign quadEnable  = sr2[fsr_pkg::SR2_QUAD];
    assign writeEnable = write_enable_latch;

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode
    assign fullOpcode = frameSys.byteCnt != 3'h0;
    // In quad mode the protect pin carries data and no longer locks status
    assign wpHigh     = wpSync | sr2[fsr_pkg::SR2_QUAD];
    assign wrsrOk     = write_enable_latch && frameSys.bitPhase == 3'h0
                        && (frameSys.byteCnt == 3'h2 || frameSys.byteCnt == 3'h3)
                        && fsr_pkg::protAllow(sr2[fsr_pkg::SR2_MODE_HI],
                                              sr1[fsr_pkg::SR1_MODE_LO], wpHigh);

    always_comb begin
        secBlocked = 1'b0;
        if (frameSys.opcode == fsr_pkg::OP_SEC_PROGRAM || frameSys.opcode == fsr_pkg::OP_SEC_ERASE) begin
            case (frameSys.data2)
                8'h01:   secBlocked = pageLock[0];
                8'h02:   secBlocked = pageLock[1];
                8'h03:   secBlocked = pageLock[2];
                default: secBlocked = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_sr1 = sr1;
        next_sr2 = sr2;
        if (frameAct && fullOpcode && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && wrsrOk) begin
            next_sr1 = frameSys.data1 & fsr_pkg::SR1_WRITE_MASK;
            if (frameSys.byteCnt == 3'h3) begin
                next_sr2 = frameSys.data2 & fsr_pkg::SR2_WRITE_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Non-volatile status bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            if (nvInit) begin
                sr1 <= fsr_pkg::SR1_RESET;
                sr2 <= fsr_pkg::SR2_RESET;
            end else if (sr2[fsr_pkg::SR2_MODE_HI] && !sr1[fsr_pkg::SR1_MODE_LO]) begin
                sr2[fsr_pkg::SR2_MODE_HI] <= 1'b0;
            end
        end else begin
            sr1 <= next_sr1;
            sr2 <= next_sr2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write-enable latch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
        end else if (opDone) begin
            write_enable_latch <= 1'b0;
        end else if (frameAct && fullOpcode) begin
            if (frameSys.opcode == fsr_pkg::OP_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1;
            end else if (frameSys.opcode == fsr_pkg::OP_WRITE_DISABLE) begin
                write_enable_latch <= 1'b0;
            end else if (fsr_pkg::isGated(frameSys.opcode)) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hand-off of accepted program and erase commands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmdStart  <= 1'b0;
            cmdOpcode <= 8'h00;
        end else begin
            cmdStart <= frameAct && fullOpcode && write_enable_latch && !secBlocked
                        && fsr_pkg::isGated(frameSys.opcode)
                        && frameSys.opcode != fsr_pkg::OP_WRITE_STATUS;
            if (frameAct && fullOpcode) begin
                cmdOpcode <= frameSys.opcode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_reserved_zero;
        @(posedge clk_sys) disable iff (rst)
        !statusByte2[7] && !statusByte2[2] && protCfg.protect_invert == statusByte2[6];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero");

    property p_wel_reset;
        @(posedge clk_sys) rst |=> !write_enable_latch && !cmdStart;
    endproperty
    a_wel_reset: assert property (p_wel_reset) else $error("latch set after reset");

    property p_lockdown_power;
        @(posedge clk_sys) rst && !nvInit && sr2[0] && !sr1[7] |=> !sr2[0] && !sr1[7];
    endproperty
    a_lockdown_power: assert property (p_lockdown_power) else $error("lock-down kept over power cycle");

    property p_mode_locked;
        @(posedge clk_sys) disable iff (rst)
        sr2[0] |=> $stable(sr1) && $stable(sr2);
    endproperty
    a_mode_locked: assert property (p_mode_locked) else $error("status changed while locked");

    property p_wp_block;
        @(posedge clk_sys) disable iff (rst)
        frameAct && fullOpcode && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && !sr2[0] && sr1[7] && !wpHigh
        |=> $stable(sr1) && $stable(sr2) && !write_enable_latch;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("write accepted with protect pin low");

    property p_accept_mode0;
        @(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && write_enable_latch && !sr2[0] && !sr1[7]
        && frameSys.bitPhase == 3'h0 && frameSys.byteCnt == 3'h3
        |=> sr1 == ($past(frameSys.data1) & 8'hFC) && sr2 == ($past(frameSys.data2) & 8'h7B) && !write_enable_latch;
    endproperty
    a_accept_mode0: assert property (p_accept_mode0) else $error("status write not taken");

    property p_partial_abort;
        @(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && fullOpcode && frameSys.bitPhase != 3'h0
        |=> $stable(sr1) && $stable(sr2) && !write_enable_latch;
    endproperty
    a_partial_abort: assert property (p_partial_abort) else $error("partial status write acted");

    property p_gate;
        @(posedge clk_sys) disable iff (rst)
        frameAct && !write_enable_latch |=> !cmdStart;
    endproperty
    a_gate: assert property (p_gate) else $error("command started without latch");

    property p_gated_clear;
        @(posedge clk_sys) disable iff (rst)
        frameAct && fullOpcode && (fsr_pkg::isGated(frameSys.opcode) || frameSys.opcode == 8'h04) |=> !write_enable_latch;
    endproperty
    a_gated_clear: assert property (p_gated_clear) else $error("latch not cleared");

    property p_no_opcode_keep;
        @(posedge clk_sys) disable iff (rst)
        frameAct && !fullOpcode && write_enable_latch && !opDone |=> write_enable_latch;
    endproperty
    a_no_opcode_keep: assert property (p_no_opcode_keep) else $error("latch lost on partial opcode");

    property p_sec_lock;
        @(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == 8'h44 && frameSys.data2 == 8'h01 && pageLock[0] |=> !cmdStart;
    endproperty
    a_sec_lock: assert property (p_sec_lock) else $error("locked page erase started");

    property p_wel_set;
        @(posedge clk_sys) disable iff (rst)
        frameAct && fullOpcode && frameSys.opcode == fsr_pkg::OP_WRITE_ENABLE && !opDone |=> write_enable_latch;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set by write enable");

    property p_done_clear;
        @(posedge clk_sys) disable iff (rst)
        opDone |=> !write_enable_latch;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("latch kept after operation end");

    property p_one_byte_keep;
        @(posedge clk_sys) disable iff (rst)
        frameAct && fullOpcode && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && frameSys.byteCnt == 3'h2
        |=> $stable(sr2);
    endproperty
    a_one_byte_keep: assert property (p_one_byte_keep) else $error("byte two changed by one-byte write");

    property p_no_latch_refuse;
        @(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && !write_enable_latch |=> $stable(sr1) && $stable(sr2);
    endproperty
    a_no_latch_refuse: assert property (p_no_latch_refuse) else $error("status written without latch");

    property p_cmd_gated;
        @(posedge clk_sys) disable iff (rst)
        cmdStart |-> fsr_pkg::isGated(cmdOpcode) && cmdOpcode != fsr_pkg::OP_WRITE_STATUS;
    endproperty
    a_cmd_gated: assert property (p_cmd_gated) else $error("start for a command that is not gated");

    property p_otp_keep;
        @(posedge clk_sys)
        rst && !nvInit && sr2[fsr_pkg::SR2_MODE_HI] && sr1[fsr_pkg::SR1_MODE_LO]
        |=> sr2[fsr_pkg::SR2_MODE_HI] && sr1[fsr_pkg::SR1_MODE_LO];
    endproperty
    a_otp_keep: assert property (p_otp_keep) else $error("one-time protection lost over power cycle");

    c_wrsr_done: cover property (@(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && wrsrOk);
    c_cmd_start: cover property (@(posedge clk_sys) disable iff (rst) cmdStart);
    c_wp_reject: cover property (@(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && write_enable_latch && !wpHigh && sr1[7]);
    c_lockdown_cycle: cover property (@(posedge clk_sys)
        rst && !nvInit && sr2[fsr_pkg::SR2_MODE_HI] && !sr1[fsr_pkg::SR1_MODE_LO]);
    c_partial_abort: cover property (@(posedge clk_sys) disable iff (rst)
        frameAct && frameSys.opcode == fsr_pkg::OP_WRITE_STATUS && fullOpcode && frameSys.bitPhase != 3'h0);
endmodule // fsr_status_protect

/* fsr_spi_host.sv */
`timescale 1ns/100ps
module fsr_spi_host (
    output logic      sck,
    output logic      csN,
    output logic      si,
    input  wire logic so,
    input  wire logic soOe
);
    localparam time HALF = 15;

    initial begin
        sck = 1'b0;
        si  = 1'b0;
        // A select rising after time zero clears the link's frame flags
        csN = 1'b0;
        #1 csN = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode 0 frame: si set while sck low, so sampled on each rising edge
    task automatic xfer(input logic [39:0] data, input int nBits, output logic [7:0] rdByte);
        rdByte = 8'h00;
        csN = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            si = data[39-i];
            #HALF sck = 1'b1;
            rdByte = {rdByte[6:0], so};
            #HALF sck = 1'b0;
        end
        #HALF csN = 1'b1;
        // Released line must not keep showing the last bit
        si = ~si;
        // Hold deselect long enough for the system side to see the frame end
        #(4 * HALF);
    endtask
endmodule // fsr_spi_host

/* tb_flash_status_protect.sv */
`timescale 1ns/100ps
module tb_flash_status_protect;
    typedef struct packed {
        logic       we;
        logic       wp;
        logic [4:0] nb;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] e1;
        logic [7:0] e2;
    } fsr_row_t;

    logic                clkSys = 1'b0;
    logic                rst    = 1'b1;
    logic                nvInit = 1'b1;
    logic                busyIn = 1'b0;
    logic                opDone = 1'b0;
    logic                wpN    = 1'b1;
    logic                sck;
    logic                csN;
    logic                si;
    logic                so;
    logic                soOe;
    fsr_pkg::fsr_prot_t  protCfg;
    logic [2:0]          pageLock;
    logic                quadEnable;
    logic                writeEnable;
    logic                cmdStart;
    logic [7:0]          cmdOpcode;
    int                  err_count = 0;
    int                  checked   = 0;
    int                  cycles    = 0;
    int                  starts    = 0;
    int                  base;
    logic [7:0]          ops [8]   = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h42, 8'h44};
    int                  opBits [8] = '{40, 32, 32, 32, 8, 8, 40, 32};
    fsr_row_t            rows [9]  = '{
        '{1'b0, 1'b1, 5'h18, 8'hFC, 8'h7B, 8'h00, 8'h00},
        '{1'b1, 1'b1, 5'h08, 8'h5D, 8'h00, 8'h5C, 8'h00},
        '{1'b1, 1'b1, 5'h10, 8'h20, 8'hFE, 8'h20, 8'h7A},
        '{1'b1, 1'b1, 5'h0C, 8'hFC, 8'h00, 8'h20, 8'h7A},
        '{1'b1, 1'b1, 5'h10, 8'h80, 8'h00, 8'h80, 8'h00},
        '{1'b1, 1'b0, 5'h10, 8'h84, 8'h00, 8'h80, 8'h00},
        '{1'b1, 1'b1, 5'h10, 8'h88, 8'h00, 8'h88, 8'h00},
        '{1'b1, 1'b1, 5'h10, 8'h08, 8'h01, 8'h08, 8'h01},
        '{1'b1, 1'b1, 5'h10, 8'h00, 8'h00, 8'h08, 8'h01}};

    always #2.5 clkSys = ~clkSys;

    fsr_status_protect u_fsr_status_protect (
        .clk_sys     (clkSys),
        .rst         (rst),
        .nvInit      (nvInit),
        .busyIn      (busyIn),
        .opDone      (opDone),
        .sck         (sck),
        .csN         (csN),
        .si          (si),
        .wpN         (wpN),
        .so          (so),
        .soOe        (soOe),
        .protCfg     (protCfg),
        .pageLock    (pageLock),
        .quadEnable  (quadEnable),
        .writeEnable (writeEnable),
        .cmdStart    (cmdStart),
        .cmdOpcode   (cmdOpcode)
    );

    fsr_spi_host u_fsr_spi_host (
        .sck  (sck),
        .csN  (csN),
        .si   (si),
        .so   (so),
        .soOe (soOe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic complete_run();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clkSys) begin
        cycles <= cycles + 1;
        if (cmdStart === 1'b1)
            starts <= starts + 1;
        if (cycles == 60000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clkSys);
    endtask

    task automatic frm(input logic [39:0] d, input int n);
        logic [7:0] r;
        u_fsr_spi_host.xfer(d, n, r);
        cyc(12);
    endtask

    task automatic wen();
        frm({fsr_pkg::OP_WRITE_ENABLE, 32'h0}, 8);
    endtask

    task automatic wrSr(input logic [7:0] d1, input logic [7:0] d2, input int nb);
        frm({fsr_pkg::OP_WRITE_STATUS, d1, d2, 16'h0}, 8 + nb);
    endtask

    task automatic checkSr(input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] v;
        u_fsr_spi_host.xfer({fsr_pkg::OP_READ_STATUS1, 32'h0}, 32, v);
        chk8("statusByte1", e1, v);
        u_fsr_spi_host.xfer({fsr_pkg::OP_READ_STATUS2, 32'h0}, 32, v);
        chk8("statusByte2", e2, v);
        cyc(12);
        chk1("soOe", 1'b0, soOe);
        chk8("protCfg", {e2[6], e1[6:2], 2'b00}, {protCfg, 2'b00});
        chk8("pageLockQuad", {4'h0, e2[5:3], e2[1]}, {4'h0, pageLock, quadEnable});
    endtask

    task automatic rstDo(input logic nv);
        rst <= 1'b1;
        nvInit <= nv;
        cyc(10);
        rst <= 1'b0;
        nvInit <= 1'b0;
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstDo(1'b1);
        foreach (rows[i]) begin
            wpN <= rows[i].wp;
            if (rows[i].we)
                wen();
            wrSr(rows[i].d1, rows[i].d2, int'(rows[i].nb));
            checkSr(rows[i].e1, rows[i].e2);
            chk1("writeEnable", 1'b0, writeEnable);
        end
        wen();
        rstDo(1'b0);
        chk1("writeEnable", 1'b0, writeEnable);
        checkSr(8'h08, 8'h00);
        busyIn <= 1'b1;
        cyc(3);
        checkSr(8'h09, 8'h00);
        busyIn <= 1'b0;
        wen();
        chk1("writeEnable", 1'b1, writeEnable);
        frm({fsr_pkg::OP_WRITE_STATUS, 32'h0}, 5);
        chk1("writeEnable", 1'b1, writeEnable);
        frm({8'h3C, 32'h0}, 8);
        chk1("writeEnable", 1'b1, writeEnable);
        frm({fsr_pkg::OP_ERASE_4K, 32'h0}, 6);
        chk1("writeEnable", 1'b1, writeEnable);
        frm({fsr_pkg::OP_ERASE_4K, 32'h0}, 12);
        chk1("writeEnable", 1'b0, writeEnable);
        wen();
        frm({fsr_pkg::OP_WRITE_DISABLE, 32'h0}, 8);
        chk1("writeEnable", 1'b0, writeEnable);
        wen();
        opDone <= 1'b1;
        cyc(1);
        opDone <= 1'b0;
        cyc(2);
        chk1("writeEnable", 1'b0, writeEnable);
        foreach (ops[i]) begin
            base = starts;
            frm({ops[i], 24'h000100, 8'hA5}, opBits[i]);
            chk8("startsNoLatch", 8'(base), 8'(starts));
            wen();
            frm({ops[i], 24'h000100, 8'hA5}, opBits[i]);
            chk8("startsLatch", 8'(base + 1), 8'(starts));
            chk8("cmdOpcode", ops[i], cmdOpcode);
            chk1("writeEnable", 1'b0, writeEnable);
        end
        wen();
        wrSr(8'h08, 8'h08, 16);
        checkSr(8'h08, 8'h08);
        base = starts;
        wen();
        frm({fsr_pkg::OP_SEC_ERASE, 24'h000100, 8'h00}, 32);
        chk8("startsLocked", 8'(base), 8'(starts));
        chk1("writeEnable", 1'b0, writeEnable);
        wen();
        wrSr(8'h80, 8'h09, 16);
        checkSr(8'h80, 8'h09);
        wen();
        wrSr(8'h00, 8'h00, 16);
        checkSr(8'h80, 8'h09);
        rstDo(1'b0);
        checkSr(8'h80, 8'h09);
        complete_run();
    end
endmodule // tb_flash_status_protect
